// *** hw/bsed_flash_end.sv ***
// flash end: block and sector erase decode and self-timed erase
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - block erase clears eight aligned pages
// - 528 block: 50h, dummy, ten page bits, 13 dummies
// - 512 block: 50h, 2 dummies, block bits, 12 dummies
// - block from ten upper page bits, 0-1023
// - cs rise starts block erase within limit
// - busy during erase, ready when done
// - failed byte verify sets error flag
// - 64 sectors, one sector per command
// - 528 sub-sector 0a/0b: 7Ch, same layout
// - 512 sub-sector 0a/0b: 7Ch, block bit layout
// - 512 sectors 1-63: 7Ch, sector bits, 16 dummies
// - sector from top six page bits; 0a/0b by bit3
// - cs rise starts sector erase within limit
// - erased bytes read back all ones
module bsed_flash_end #(
	parameter int unsigned BLOCK_ERASE_CYC  = bsed_pkg::BLOCK_ERASE_TIME_US * bsed_pkg::CLK_MHZ,
	parameter int unsigned SECTOR_ERASE_CYC = bsed_pkg::SECTOR_ERASE_TIME_US * bsed_pkg::CLK_MHZ
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	// link
	bsed_link_if.flash        link,
	// configuration
	input  wire logic         page_512,
	// array side
	input  wire logic         arr_verify_bad,
	output var  logic         arr_erase_go,
	output var  logic [12:0]  arr_first_page,
	output var  logic [7:0]   arr_page_count,
	output var  logic [7:0]   arr_fill_byte,
	output var  logic         arr_erasing,
	// status
	output var  logic         status_ready,
	output var  logic         erase_program_error_flag
);
	typedef enum logic [1:0] {BSED_IDLE, BSED_ERASE, BSED_FINISH} bsed_state_t;

	localparam int unsigned TMR_W = $clog2(BLOCK_ERASE_CYC > SECTOR_ERASE_CYC ?
		BLOCK_ERASE_CYC + 1 : SECTOR_ERASE_CYC + 1);

	// page number out of the address bytes
	function automatic logic [12:0] page_of(input logic [23:0] a, input logic p512);
		logic [23:0] s;
		s = p512 ? (a >> bsed_pkg::PAGE_LSB_512) : (a >> bsed_pkg::PAGE_LSB_528);
		return s[12:0];
	endfunction : page_of

	// link synchronisers
	logic        cs_m;
	logic        cs_s;
	logic        cs_d;
	logic        sck_m;
	logic        sck_s;
	logic        sck_d;
	logic        si_m;
	logic        si_s;
	// frame capture
	logic [31:0] shreg;
	logic [5:0]  bit_cnt;
	// erase engine
	bsed_state_t state;
	bsed_state_t next_state;
	logic [TMR_W-1:0] timer;

	// chip select: two flops, then an edge-detect stage
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cs_m <= 1'b1;
			cs_s <= 1'b1;
			cs_d <= 1'b1;
		end else begin
			cs_m <= link.cs_n;
			cs_s <= cs_m;
			cs_d <= cs_s;
		end
	end

	// serial clock: two flops, then an edge-detect stage
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sck_m <= 1'b0;
			sck_s <= 1'b0;
			sck_d <= 1'b0;
		end else begin
			sck_m <= link.sck;
			sck_s <= sck_m;
			sck_d <= sck_s;
		end
	end

	// serial data: same depth as the clock path, so bits line up
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			si_m <= 1'b0;
			si_s <= 1'b0;
		end else begin
			si_m <= link.si;
			si_s <= si_m;
		end
	end

	wire sck_rise = sck_s & ~sck_d & ~cs_s;
	wire cs_rise  = cs_s & ~cs_d;

	// opcode and address split
	wire [7:0]  opcode   = shreg[31:24];
	wire [23:0] addr     = shreg[23:0];
	wire [12:0] page     = page_of(addr, page_512);
	wire        frame_ok = (bit_cnt == 6'(bsed_pkg::CMD_BITS));
	wire        is_block = (opcode == bsed_pkg::OP_BLOCK_ERASE);
	wire        is_sect  = (opcode == bsed_pkg::OP_SECTOR_ERASE);
	wire        start    = cs_rise & frame_ok & (is_block | is_sect) & (state == BSED_IDLE);

	// unit selection
	wire [9:0]  block_num = 10'(page >> bsed_pkg::BLOCK_SHIFT);
	wire [5:0]  sect_num  = 6'(page >> bsed_pkg::SECTOR_SHIFT);
	wire        sect_zero = (sect_num == 6'h00);
	wire        sub_0b    = page[bsed_pkg::BLOCK_SHIFT];
	wire [12:0] blk_first = 13'(block_num) << bsed_pkg::BLOCK_SHIFT;
	wire [12:0] sec_first = sect_zero ? (sub_0b ? bsed_pkg::SUB0B_FIRST : 13'h0000)
	                                  : 13'(sect_num) << bsed_pkg::SECTOR_SHIFT;
	wire [7:0]  sec_count = sect_zero ? (sub_0b ? bsed_pkg::SUB0B_PAGES : bsed_pkg::SUB0A_PAGES)
	                                  : bsed_pkg::SECTOR_PAGES;
	wire [12:0] next_first = is_block ? blk_first : sec_first;
	wire [7:0]  next_count = is_block ? bsed_pkg::BLOCK_PAGES : sec_count;
	wire [TMR_W-1:0] next_limit = is_block ? TMR_W'(BLOCK_ERASE_CYC)
	                                       : TMR_W'(SECTOR_ERASE_CYC);

	// serial capture, msb first, sampled on sck rise
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			shreg   <= 32'h0000_0000;
			bit_cnt <= 6'h00;
		end else if (cs_s) begin
			bit_cnt <= 6'h00;
		end else if (sck_rise) begin
			shreg <= {shreg[30:0], si_s};
			if (bit_cnt <= 6'(bsed_pkg::CMD_BITS))
				bit_cnt <= bit_cnt + 6'h01;
		end
	end

	// erase engine
	wire timer_done = (timer == {TMR_W{1'b0}});

	always_comb begin
		next_state = state;
		case (state)
			BSED_IDLE:   if (start) next_state = BSED_ERASE;
			BSED_ERASE:  if (timer_done) next_state = BSED_FINISH;
			BSED_FINISH: next_state = BSED_IDLE;
			default:     next_state = BSED_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= BSED_IDLE;
			timer <= {TMR_W{1'b0}};
		end else begin
			state <= next_state;
			if (start)
				timer <= next_limit - TMR_W'(1);
			else if (state == BSED_ERASE && !timer_done)
				timer <= timer - TMR_W'(1);
		end
	end

	// array command and status outputs
	wire err_set = (state == BSED_ERASE) & arr_verify_bad;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			arr_erase_go  <= 1'b0;
			arr_fill_byte <= bsed_pkg::ERASED_BYTE;
			arr_erasing   <= 1'b0;
			status_ready  <= 1'b1;
		end else begin
			arr_erase_go  <= start;
			arr_fill_byte <= bsed_pkg::ERASED_BYTE;
			arr_erasing   <= (next_state == BSED_ERASE);
			status_ready  <= (next_state == BSED_IDLE);
		end
	end

	// erase unit, held for the array until the next accepted command
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			arr_first_page <= 13'h0000;
			arr_page_count <= 8'h00;
		end else if (start) begin
			arr_first_page <= next_first;
			arr_page_count <= next_count;
		end
	end

	// sticky error flag, cleared only when a new erase is accepted
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			erase_program_error_flag <= 1'b0;
		else if (start)
			erase_program_error_flag <= 1'b0;
		else if (err_set)
			erase_program_error_flag <= 1'b1;
	end
endmodule : bsed_flash_end
`default_nettype wire

// *** hw/bsed_pkg.sv ***
// shared constants for the block/sector erase link
package bsed_pkg;
	localparam int unsigned CLK_MHZ       = 250;
	localparam int unsigned CLK_PERIOD_NS = 4;
	// opcodes
	localparam logic [7:0] OP_BLOCK_ERASE  = 8'h50;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h7c;
	// command frame
	localparam int unsigned CMD_BITS = 32;
	localparam int unsigned ADDR_W   = 24;
	localparam int unsigned PAGE_W   = 13;
	localparam int unsigned BLOCK_W  = 10;
	localparam int unsigned SECTOR_W = 6;
	localparam int unsigned CNT_W    = 8;
	// page field position in the address bytes per page-size option
	localparam int unsigned PAGE_LSB_528 = 10;
	localparam int unsigned PAGE_LSB_512 = 9;
	// page counts and first pages of erase units
	localparam logic [7:0]  BLOCK_PAGES  = 8'h08;
	localparam logic [7:0]  SECTOR_PAGES = 8'h80;
	localparam logic [7:0]  SUB0A_PAGES  = 8'h08;
	localparam logic [7:0]  SUB0B_PAGES  = 8'h78;
	localparam logic [12:0] SUB0B_FIRST  = 13'h0008;
	localparam int unsigned BLOCK_SHIFT  = 3;
	localparam int unsigned SECTOR_SHIFT = 7;
	localparam logic [7:0]  ERASED_BYTE  = 8'hff;
	// erase time limits, microseconds
	localparam int unsigned BLOCK_ERASE_TIME_US  = 100;
	localparam int unsigned SECTOR_ERASE_TIME_US = 400;
	// link timing
	localparam int unsigned SCK_PERIOD_NS = 80;
	localparam int unsigned SCK_HALF_CYC  = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int unsigned CS_HIGH_NS    = 40;
	localparam int unsigned CS_HIGH_CYC   = (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : bsed_pkg

// *** hw/bsed_link_if.sv ***
// serial link between host controller and flash erase end
`timescale 1ns/10ps
`default_nettype none
interface bsed_link_if;
	logic cs_n;
	logic sck;
	logic si;
	modport flash (input cs_n, input sck, input si);
	modport host  (output cs_n, output sck, output si);
endinterface : bsed_link_if
`default_nettype wire

// *** hw/bsed_host_end.sv ***
// host end: builds and sends block and sector erase commands
`timescale 1ns/10ps
`default_nettype none
module bsed_host_end (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// user request
	input  wire logic        req_valid,
	input  wire logic        req_is_sector,
	input  wire logic [12:0] req_page,
	input  wire logic        page_512,
	output var  logic        req_ready,
	// link
	bsed_link_if.host        link
);
	typedef enum logic [1:0] {BSEH_IDLE, BSEH_SHIFT, BSEH_GAP} bseh_state_t;

	// address bytes for the chosen command and page-size option
	function automatic logic [23:0] addr_of(input logic sect, input logic [12:0] pg,
		input logic p512);
		int unsigned sh;
		int unsigned lsb;
		sh  = bsed_pkg::BLOCK_SHIFT;
		if (sect && (pg >> bsed_pkg::SECTOR_SHIFT) != 13'h0000)
			sh = bsed_pkg::SECTOR_SHIFT;
		lsb = p512 ? bsed_pkg::PAGE_LSB_512 : bsed_pkg::PAGE_LSB_528;
		return 24'(pg >> sh) << (lsb + sh);
	endfunction : addr_of

	bseh_state_t state;
	logic [31:0] shreg;
	logic [5:0]  bit_cnt;
	logic [4:0]  div;
	logic [4:0]  gap;
	logic        cs_n;
	logic        sck;
	logic        si;

	wire        half_tick = (div == 5'(bsed_pkg::SCK_HALF_CYC - 1));
	wire [7:0]  opcode    = req_is_sector ? bsed_pkg::OP_SECTOR_ERASE : bsed_pkg::OP_BLOCK_ERASE;
	wire        accept    = (state == BSEH_IDLE) & req_valid;
	wire        last_bit  = (bit_cnt == 6'(bsed_pkg::CMD_BITS - 1));
	wire        gap_done  = (gap == 5'(bsed_pkg::CS_HIGH_CYC - 1));

	assign link.cs_n = cs_n;
	assign link.sck  = sck;
	assign link.si   = si;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state     <= BSEH_IDLE;
			shreg     <= 32'h0000_0000;
			bit_cnt   <= 6'h00;
			div       <= 5'h00;
			gap       <= 5'h00;
			cs_n      <= 1'b1;
			sck       <= 1'b0;
			si        <= 1'b0;
			req_ready <= 1'b1;
		end else begin
			case (state)
				BSEH_IDLE: begin
					if (accept) begin
						shreg     <= {opcode, addr_of(req_is_sector, req_page, page_512)};
						si        <= opcode[7];
						cs_n      <= 1'b0;
						bit_cnt   <= 6'h00;
						div       <= 5'h00;
						req_ready <= 1'b0;
						state     <= BSEH_SHIFT;
					end
				end
				BSEH_SHIFT: begin
					div <= half_tick ? 5'h00 : div + 5'h01;
					if (half_tick) begin
						sck <= ~sck;
						if (sck) begin
							if (last_bit) begin
								cs_n  <= 1'b1;
								gap   <= 5'h00;
								state <= BSEH_GAP;
							end else begin
								shreg   <= {shreg[30:0], 1'b0};
								si      <= shreg[30];
								bit_cnt <= bit_cnt + 6'h01;
							end
						end
					end
				end
				BSEH_GAP: begin
					gap <= gap + 5'h01;
					if (gap_done) begin
						req_ready <= 1'b1;
						state     <= BSEH_IDLE;
					end
				end
				default: state <= BSEH_IDLE;
			endcase
		end
	end
endmodule : bsed_host_end
`default_nettype wire

// *** test/bsed_assertions.sv ***
// checker for the erase link and the flash end status
`timescale 1ns/10ps
`default_nettype none
module bsed_assertions #(
	parameter int unsigned BLOCK_ERASE_CYC  = bsed_pkg::BLOCK_ERASE_TIME_US * bsed_pkg::CLK_MHZ,
	parameter int unsigned SECTOR_ERASE_CYC = bsed_pkg::SECTOR_ERASE_TIME_US * bsed_pkg::CLK_MHZ
) (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	// link and status
	input wire logic       cs_n,
	input wire logic       sck,
	input wire logic       si,
	input wire logic       arr_verify_bad,
	input wire logic       arr_erase_go,
	input wire logic [7:0] arr_page_count,
	input wire logic [7:0] arr_fill_byte,
	input wire logic       arr_erasing,
	input wire logic       status_ready,
	input wire logic       erase_program_error_flag
);
	// cycles status_ready has stood low
	logic [31:0] busy_cnt;

	always_ff @(posedge sys_clk) begin
		if (sys_rst || status_ready)
			busy_cnt <= 32'h0000_0000;
		else
			busy_cnt <= busy_cnt + 32'h0000_0001;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	AST_GO_BUSY: assert property (arr_erase_go |-> !status_ready && arr_erasing)
		else $error("no busy at erase start");
	AST_COUNT: assert property (arr_erase_go |-> arr_page_count inside {8'h08, 8'h78, 8'h80})
		else $error("bad page count");
	AST_BUSY_LEN: assert property ($rose(status_ready) |-> busy_cnt == 32'(BLOCK_ERASE_CYC + 1) || busy_cnt == 32'(SECTOR_ERASE_CYC + 1))
		else $error("busy time wrong");
	AST_GO_CS: assert property (arr_erase_go |-> cs_n && $past(cs_n, 3))
		else $error("erase start without cs rise");
	AST_READY_DONE: assert property ($rose(status_ready) |-> !arr_erasing && $past(arr_erasing, 2))
		else $error("ready before erase end");
	AST_ERR_SET: assert property (arr_erasing && arr_verify_bad |=> erase_program_error_flag)
		else $error("error flag not set");
	AST_ERR_HOLD: assert property (erase_program_error_flag |=> erase_program_error_flag || arr_erase_go)
		else $error("error flag lost");
	AST_FILL: assert property (arr_fill_byte == 8'hff)
		else $error("fill not ones");
	AST_SCK_IDLE: assert property (cs_n |-> !sck)
		else $error("sck moves outside frame");
	AST_SI_STABLE: assert property (!cs_n && sck |-> $stable(si))
		else $error("si moves while sck high");
	cover property (arr_erase_go && arr_page_count == 8'h78);
	cover property (arr_erasing && arr_verify_bad);
	cover property ($rose(status_ready));
endmodule : bsed_assertions
`default_nettype wire

// *** test/block_sector_erase_decoder_bench.sv ***
// bench: host end and flash end face to face
`timescale 1ns/10ps
`default_nettype none
module block_sector_erase_decoder_bench;
	logic        sys_clk = 0;
	logic        sys_rst = 1;
	logic        rv = 0, rs = 0, p5 = 0, bad = 0, inj = 0, sd = 0, p52 = 0;
	logic [12:0] rp = 0;
	logic        rr, go, go2, rdy, err, ers;
	logic [12:0] fp, cf;
	logic [7:0]  pc, cc, fill;
	logic [31:0] frame;
	int          err_total = 0, cmp_count = 0, cyc = 0, gn = 0, gn2 = 0;
	bsed_link_if lk ();
	bsed_link_if lk2 ();
	bsed_host_end i_bsed_host_end (.sys_clk(sys_clk), .sys_rst(sys_rst), .req_valid(rv),
		.req_is_sector(rs), .req_page(rp), .page_512(p5), .req_ready(rr), .link(lk.host));
	bsed_flash_end #(.BLOCK_ERASE_CYC(40), .SECTOR_ERASE_CYC(80)) i_bsed_flash_end (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .link(lk.flash), .page_512(p5),
		.arr_verify_bad(bad), .arr_erase_go(go), .arr_first_page(fp), .arr_page_count(pc),
		.arr_fill_byte(fill), .arr_erasing(ers), .status_ready(rdy),
		.erase_program_error_flag(err));
	// second flash end, fed by hand-made frames
	bsed_flash_end i_bsed_flash_end_2 (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .link(lk2.flash), .page_512(p52),
		.arr_verify_bad(1'b0), .arr_erase_go(go2), .arr_first_page(), .arr_page_count(),
		.arr_fill_byte(), .arr_erasing(), .status_ready(), .erase_program_error_flag());
	bsed_assertions #(.BLOCK_ERASE_CYC(40), .SECTOR_ERASE_CYC(80)) i_bsed_assertions (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n(lk.cs_n),
		.sck(lk.sck), .si(lk.si), .arr_verify_bad(bad), .arr_erase_go(go),
		.arr_page_count(pc), .arr_fill_byte(fill), .arr_erasing(ers), .status_ready(rdy),
		.erase_program_error_flag(err));
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		sd <= lk.sck;
		if (lk.sck && !sd && !lk.cs_n)
			frame <= {frame[30:0], lk.si};
		if (go) begin
			gn <= gn + 1;
			cf <= fp;
			cc <= pc;
		end
		if (go2)
			gn2 <= gn2 + 1;
		bad <= inj && ers;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic send(input logic sec, input logic [12:0] pg, input logic o5);
		int n, g, sh;
		logic [12:0] ef;
		logic [7:0] ec;
		g = gn;
		n = 0;
		sh = (sec && pg[12:7] != 0) ? 7 : 3;
		ef = !sec ? {pg[12:3], 3'b000} : pg[12:7] != 0 ? {pg[12:7], 7'h00} : pg[3] ? 13'h0008 : 13'h0000;
		ec = !sec ? 8'h08 : pg[12:7] != 0 ? 8'h80 : pg[3] ? 8'h78 : 8'h08;
		rs <= sec;
		rp <= pg;
		p5 <= o5;
		rv <= 1;
		@(posedge sys_clk);
		rv <= 0;
		@(posedge sys_clk);
		while (!(rdy === 1 && rr === 1 && gn != g) && n < 3000) begin
			@(posedge sys_clk);
			n++;
		end
		chk(gn, g + 1);
		chk(frame[31:24], sec ? 8'h7c : 8'h50);
		chk(frame[23:0] >> ((o5 ? 9 : 10) + sh), pg >> sh);
		chk(cf, ef);
		chk(cc, ec);
	endtask : send
	task automatic t_erase();
		logic [12:0] pages [6] = '{13'h0007, 13'h1fff, 13'h0003, 13'h000c, 13'h0085, 13'h1f80};
		for (int i = 0; i < 24; i++)
			send((i / 6) % 2 == 1, pages[i % 6], i >= 12);
		$display("erase table done");
	endtask : t_erase
	task automatic t_error();
		inj = 1;
		send(1'b0, 13'h0010, 1'b0);
		inj = 0;
		chk(err, 1'b1);
		send(1'b1, 13'h0100, 1'b1);
		chk(err, 1'b0);
		$display("error flag done");
	endtask : t_error
	task automatic put(input logic [31:0] w, input int nb);
		lk2.cs_n <= 0;
		for (int i = 31; i > 31 - nb; i--) begin
			lk2.si <= w[i];
			repeat (10) @(posedge sys_clk);
			lk2.sck <= 1;
			repeat (10) @(posedge sys_clk);
			lk2.sck <= 0;
		end
		repeat (10) @(posedge sys_clk);
		lk2.cs_n <= 1;
		lk2.si <= ~w[32 - nb];
		repeat (20) @(posedge sys_clk);
	endtask : put
	task automatic t_refuse();
		int g;
		p52 <= 1'b1;
		g = gn2;
		put(32'h5100_0400, 32);
		put(32'h5000_0400, 31);
		chk(gn2, g);
		put(32'h7c00_0400, 32);
		chk(gn2, g + 1);
		$display("refusal done");
	endtask : t_refuse
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		lk2.cs_n = 1;
		lk2.sck = 0;
		lk2.si = 0;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 0;
		repeat (4) @(posedge sys_clk);
		t_erase();
		t_error();
		t_refuse();
		chk(fill, 8'hff);
		wrap_up();
	end
endmodule : block_sector_erase_decoder_bench
`default_nettype wire
